// ==== flash_ctrl_pkg.sv ====
// Package with register offsets, command codes and state encodings.
package flash_ctrl_pkg;

	// ****************************************************************
	// Register file addresses
	// ****************************************************************
	localparam logic [11:0] CTRL_STAT_ADDR = 12'hff8;
	localparam logic [11:0] PAGE_SEL_ADDR  = 12'hff9;

	// ****************************************************************
	// Control register command codes
	// ****************************************************************
	localparam logic [7:0] KEY_FIRST     = 8'h73;
	localparam logic [7:0] KEY_SECOND    = 8'h8c;
	localparam logic [7:0] CMD_PAGE_ERS  = 8'h95;
	localparam logic [7:0] CMD_SECT_SEL  = 8'h5e;

	// ****************************************************************
	// Status field codes
	// ****************************************************************
	localparam logic [5:0] ST_LOCKED   = 6'h00;
	localparam logic [5:0] ST_KEY1     = 6'h01;
	localparam logic [5:0] ST_KEY2     = 6'h02;
	localparam logic [5:0] ST_UNLOCKED = 6'h03;
	localparam logic [5:0] ST_SECT_SEL = 6'h04;
	localparam logic [5:0] ST_PROG     = 6'h08;
	localparam logic [5:0] ST_PG_ERS   = 6'h10;
	localparam logic [5:0] ST_MASS_ERS = 6'h20;

	// ****************************************************************
	// Reset values and sizes
	// ****************************************************************
	localparam logic [7:0] STATUS_RESET  = 8'h00;
	localparam logic [7:0] SECTOR_RESET  = 8'h00;
	localparam logic [7:0] PAGE_RESET    = 8'h00;
	localparam int         NUM_SECTORS   = 8;

endpackage

// ==== flash_unlock_protect_ctrl.sv ====
// Flash controller front end: unlock sequence, protection and status.
`timescale 1ns/1ps
module flash_unlock_protect_ctrl
	import flash_ctrl_pkg::*;
#(
	parameter int PAGE_W   = 8,
	parameter int OFFS_W   = 9,
	parameter int BUSY_CYC = 4
)(
	input  wire logic                     core_clk,
	input  wire logic                     nrst,
	input  wire logic [11:0]              reg_addr,
	input  wire logic [7:0]               reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic      [7:0]               reg_rdata,
	input  wire logic                     mem_wr,
	input  wire logic [PAGE_W+OFFS_W-1:0] mem_addr,
	input  wire logic [7:0]               mem_wdata,
	input  wire logic                     dbg_mass_erase,
	input  wire logic                     main_write_protect_option,
	input  wire logic                     high_sector_write_protect_option,
	output logic                          prog_req,
	output logic [PAGE_W+OFFS_W-1:0]      prog_addr,
	output logic [7:0]                    prog_data,
	output logic                          page_erase_req,
	output logic [PAGE_W-1:0]             erase_page,
	output logic                          mass_erase_req,
	output logic [5:0]                    controller_state_code
);

	// ****************************************************************
	// State machine
	// ****************************************************************
	typedef enum logic [7:0] {
		S_LOCKED   = 8'b0000_0001,
		S_KEY1     = 8'b0000_0010,
		S_KEY2     = 8'b0000_0100,
		S_UNLOCKED = 8'b0000_1000,
		S_SECT     = 8'b0001_0000,
		S_PROG     = 8'b0010_0000,
		S_PG_ERS   = 8'b0100_0000,
		S_MASS_ERS = 8'b1000_0000
	} ctrl_state_e;

	ctrl_state_e             state_r;
	ctrl_state_e             state_nxt;
	logic [PAGE_W-1:0]       page_r;
	logic [NUM_SECTORS-1:0]  sect_prot_r;
	logic                    programmed_r;
	logic [3:0]              busy_cnt_r;
	logic [7:0]              rdata_nxt;
	logic                    dbg_s1_r;
	logic                    dbg_s2_r;
	logic                    dbg_s3_r;
	logic                    opt_main_s1_r;
	logic                    opt_main_r;
	logic                    opt_high_s1_r;
	logic                    opt_high_r;
	logic                    sect_blocked;
	logic                    ctrl_wr;
	logic                    page_wr;
	logic                    mem_in_page;
	logic                    user_enable;
	logic                    dbg_rise;
	logic                    busy_done;

	assign ctrl_wr     = reg_wr && (reg_addr == CTRL_STAT_ADDR);
	assign page_wr     = reg_wr && (reg_addr == PAGE_SEL_ADDR);
	assign mem_in_page = (mem_addr[PAGE_W+OFFS_W-1:OFFS_W] == page_r);
	assign user_enable = opt_main_r;
	assign dbg_rise    = dbg_s2_r && !dbg_s3_r;
	assign busy_done   = (busy_cnt_r == 4'h0);

	sector_map #(
		.PAGE_W (PAGE_W)
	) u_sector_map (
		.page    (page_r),
		.protect (sect_prot_r),
		.blocked (sect_blocked)
	);

	// ****************************************************************
	// Input synchronisers
	// ****************************************************************
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			dbg_s1_r      <= 1'b0;
			dbg_s2_r      <= 1'b0;
			dbg_s3_r      <= 1'b0;
			opt_main_s1_r <= 1'b0;
			opt_main_r    <= 1'b0;
			opt_high_s1_r <= 1'b0;
			opt_high_r    <= 1'b0;
		end
		else
		begin
			dbg_s1_r      <= dbg_mass_erase;
			dbg_s2_r      <= dbg_s1_r;
			dbg_s3_r      <= dbg_s2_r;
			opt_main_s1_r <= main_write_protect_option;
			opt_main_r    <= opt_main_s1_r;
			opt_high_s1_r <= high_sector_write_protect_option;
			opt_high_r    <= opt_high_s1_r;
		end
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			S_LOCKED:
				if (ctrl_wr && reg_wdata == KEY_FIRST)
					state_nxt = S_KEY1;
				else if (ctrl_wr && reg_wdata == CMD_SECT_SEL)
					state_nxt = S_SECT;
			S_KEY1:
				if (ctrl_wr)
					state_nxt = (reg_wdata == KEY_SECOND) ? S_KEY2
						: S_LOCKED;
				else if (page_wr)
					state_nxt = S_LOCKED;
			S_KEY2:
				if (page_wr)
					state_nxt = (reg_wdata == page_r) ? S_UNLOCKED
						: S_LOCKED;
				else if (ctrl_wr)
					state_nxt = S_LOCKED;
			S_UNLOCKED:
				if (ctrl_wr)
				begin
					if (reg_wdata == CMD_PAGE_ERS && !programmed_r
						&& user_enable && !sect_blocked)
						state_nxt = S_PG_ERS;
					else
						state_nxt = S_LOCKED;
				end
				else if (mem_wr && mem_in_page && user_enable
					&& !sect_blocked)
					state_nxt = S_PROG;
			S_SECT:
				if (ctrl_wr)
					state_nxt = S_LOCKED;
			S_PROG:
				if (busy_done)
					state_nxt = S_UNLOCKED;
			S_PG_ERS:
				if (busy_done)
					state_nxt = S_LOCKED;
			S_MASS_ERS:
				if (busy_done)
					state_nxt = S_LOCKED;
			default:
				state_nxt = S_LOCKED;
		endcase
		// Mass erase only through the debug port, never from user code.
		if (dbg_rise && (state_r == S_LOCKED || state_r == S_UNLOCKED))
			state_nxt = S_MASS_ERS;
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			state_r <= S_LOCKED;
		else
			state_r <= state_nxt;
	end

	// ****************************************************************
	// Operation timer
	// ****************************************************************
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			busy_cnt_r <= 4'h0;
		else if (state_nxt != state_r && (state_nxt == S_PROG
			|| state_nxt == S_PG_ERS || state_nxt == S_MASS_ERS))
			busy_cnt_r <= 4'(BUSY_CYC - 1);
		else if (!busy_done)
			busy_cnt_r <= busy_cnt_r - 4'h1;
	end

	// ****************************************************************
	// Page select and sector protection
	// ****************************************************************
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			page_r <= PAGE_W'(PAGE_RESET);
		else if (page_wr && state_r == S_LOCKED)
			page_r <= reg_wdata[PAGE_W-1:0];
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			sect_prot_r <= SECTOR_RESET;
		else if (page_wr && state_r == S_SECT)
			sect_prot_r <= sect_prot_r | reg_wdata;
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			programmed_r <= 1'b0;
		else if (state_r != S_UNLOCKED && state_r != S_PROG)
			programmed_r <= 1'b0;
		else if (state_r == S_PROG)
			programmed_r <= 1'b1;
	end

	// ****************************************************************
	// Flash array requests
	// ****************************************************************
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			prog_req       <= 1'b0;
			prog_addr      <= '0;
			prog_data      <= 8'h00;
			page_erase_req <= 1'b0;
			erase_page     <= '0;
			mass_erase_req <= 1'b0;
		end
		else
		begin
			prog_req       <= state_r == S_UNLOCKED && state_nxt == S_PROG;
			page_erase_req <= state_r != S_PG_ERS && state_nxt == S_PG_ERS;
			mass_erase_req <= state_r != S_MASS_ERS
				&& state_nxt == S_MASS_ERS;
			if (state_nxt == S_PROG && state_r == S_UNLOCKED)
			begin
				prog_addr <= mem_addr;
				prog_data <= mem_wdata;
			end
			erase_page <= page_r;
		end
	end

	// ****************************************************************
	// Status and read data
	// ****************************************************************
	function automatic logic [5:0] code_of(input ctrl_state_e s);
		unique case (s)
			S_LOCKED:   code_of = ST_LOCKED;
			S_KEY1:     code_of = ST_KEY1;
			S_KEY2:     code_of = ST_KEY2;
			S_UNLOCKED: code_of = ST_UNLOCKED;
			S_SECT:     code_of = ST_SECT_SEL;
			S_PROG:     code_of = ST_PROG;
			S_PG_ERS:   code_of = ST_PG_ERS;
			S_MASS_ERS: code_of = ST_MASS_ERS;
			default:    code_of = ST_LOCKED;
		endcase
	endfunction

	always_comb
	begin
		rdata_nxt = 8'h00;
		if (reg_rd && reg_addr == CTRL_STAT_ADDR)
			rdata_nxt = {2'b00, code_of(state_r)};
		else if (reg_rd && reg_addr == PAGE_SEL_ADDR)
			rdata_nxt = (state_r == S_SECT) ? sect_prot_r
				: 8'(page_r);
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			reg_rdata             <= STATUS_RESET;
			controller_state_code <= ST_LOCKED;
		end
		else
		begin
			reg_rdata             <= rdata_nxt;
			controller_state_code <= code_of(state_nxt);
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	property p_reset_locked;
		@(posedge core_clk) $rose(nrst) |-> state_r == S_LOCKED;
	endproperty
	a_reset_locked: assert property (p_reset_locked)
		else $error("not locked after reset");

	property p_key_seq;
		@(posedge core_clk) disable iff (!nrst)
		state_r == S_LOCKED && ctrl_wr && reg_wdata == KEY_FIRST
		&& !dbg_rise |=> state_r == S_KEY1;
	endproperty
	a_key_seq: assert property (p_key_seq)
		else $error("first key not taken");

	property p_page_mismatch;
		@(posedge core_clk) disable iff (!nrst)
		state_r == S_KEY2 && page_wr && reg_wdata != page_r
		|=> state_r == S_LOCKED;
	endproperty
	a_page_mismatch: assert property (p_page_mismatch)
		else $error("mismatched page did not lock");

	property p_erase_blocked;
		@(posedge core_clk) disable iff (!nrst)
		page_erase_req |-> !$past(sect_blocked) && $past(opt_main_r);
	endproperty
	a_erase_blocked: assert property (p_erase_blocked)
		else $error("erase of protected sector");

	property p_other_locks;
		@(posedge core_clk) disable iff (!nrst)
		state_r == S_UNLOCKED && ctrl_wr && reg_wdata != CMD_PAGE_ERS
		&& !dbg_rise |=> state_r == S_LOCKED;
	endproperty
	a_other_locks: assert property (p_other_locks)
		else $error("unlocked state survived control write");

	property p_mass_debug;
		@(posedge core_clk) disable iff (!nrst)
		$rose(mass_erase_req) |-> $past(dbg_rise);
	endproperty
	a_mass_debug: assert property (p_mass_debug)
		else $error("mass erase without debug request");

	property p_prot_sticky;
		@(posedge core_clk) disable iff (!nrst)
		(sect_prot_r & $past(sect_prot_r)) == $past(sect_prot_r)
		&& (sect_prot_r == $past(sect_prot_r) || $past(page_wr));
	endproperty
	a_prot_sticky: assert property (p_prot_sticky)
		else $error("sector protection changed without write");

	property p_status_code;
		@(posedge core_clk) disable iff (!nrst)
		$past(reg_rd && reg_addr == CTRL_STAT_ADDR)
		|-> reg_rdata[7:6] == 2'b00
		&& reg_rdata[5:0] == $past(controller_state_code);
	endproperty
	a_status_code: assert property (p_status_code)
		else $error("reserved status bits set");

endmodule

// ==== sector_map.sv ====
// Page-to-sector mapper with protection lookup.
`timescale 1ns/1ps
module sector_map
	import flash_ctrl_pkg::*;
#(
	parameter int PAGE_W = 8
)(
	input  wire logic [PAGE_W-1:0]      page,
	input  wire logic [NUM_SECTORS-1:0] protect,
	output logic                        blocked
);
	logic [2:0] sector;

	// Eight sectors of one eighth each; when fewer than eight pages exist a
	// sector equals one page.
	always_comb
	begin
		if (PAGE_W >= 3)
			sector = page[PAGE_W-1 -: 3];
		else
			sector = 3'(page);
		blocked = protect[sector];
	end
endmodule

// ==== testbench.sv ====
// Self-checking testbench for the flash unlock and protection front end.
`timescale 1ns/1ps
module testbench
	import flash_ctrl_pkg::*;
;
	logic        core_clk = 1'b0;
	logic        nrst;
	logic [11:0] reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_rdata;
	logic        mem_wr;
	logic [16:0] mem_addr;
	logic [7:0]  mem_wdata;
	logic        dbg_mass_erase;
	logic        main_opt;
	logic        high_opt;
	logic        prog_req;
	logic [16:0] prog_addr;
	logic [7:0]  prog_data;
	logic        page_erase_req;
	logic [7:0]  erase_page;
	logic        mass_erase_req;
	logic [5:0]  controller_state_code;
	logic [7:0]  prot_model;
	logic [16:0] last_paddr;
	logic [7:0]  last_pdata;
	logic [7:0]  last_epage;
	logic [7:0]  pg;
	int          bad_count = 0;
	int          checked = 0;
	int          cycles = 0;
	int          n_prog = 0;
	int          n_ers = 0;
	int          n_mass = 0;

	flash_unlock_protect_ctrl u_dut (
		.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .mem_wr(mem_wr), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .dbg_mass_erase(dbg_mass_erase),
		.main_write_protect_option(main_opt),
		.high_sector_write_protect_option(high_opt),
		.prog_req(prog_req), .prog_addr(prog_addr), .prog_data(prog_data),
		.page_erase_req(page_erase_req), .erase_page(erase_page),
		.mass_erase_req(mass_erase_req),
		.controller_state_code(controller_state_code));

	always #50 core_clk = ~core_clk;

	// ****************************************************************
	// Request monitor and timeout
	// ****************************************************************
	always @(negedge core_clk)
	begin
		cycles++;
		if (prog_req === 1'b1)
		begin
			n_prog++;
			last_paddr = prog_addr;
			last_pdata = prog_data;
		end
		if (page_erase_req === 1'b1)
		begin
			n_ers++;
			last_epage = erase_page;
		end
		if (mass_erase_req === 1'b1)
			n_mass++;
		if (cycles == 20000)
		begin
			bad_count++;
			close_out();
		end
	end

	// ****************************************************************
	// Checks and bus tasks
	// ****************************************************************
	task automatic chk(input string what, input logic [16:0] exp,
		input logic [16:0] got);
		checked++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_n(input string what, input int exp, input int got);
		checked++;
		if (got != exp)
		begin
			bad_count++;
			$display("wrong value %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	task automatic close_out();
		$display("mismatches %0d of %0d checks", bad_count, checked);
		if (bad_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	function automatic int op_ok(input logic [7:0] p);
		return (main_opt && !prot_model[p[7:5]]) ? 1 : 0;
	endfunction

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge core_clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge core_clk);
		#1;
		reg_wr = 1'b0;
	endtask

	task automatic mw(input logic [16:0] a, input logic [7:0] d);
		@(posedge core_clk);
		#1;
		mem_addr = a;
		mem_wdata = d;
		mem_wr = 1'b1;
		@(posedge core_clk);
		#1;
		mem_wr = 1'b0;
	endtask

	// Reads one register; the answer stands for the cycle after the strobe.
	task automatic rd(input logic [11:0] a, input string what,
		input logic [7:0] exp);
		@(posedge core_clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge core_clk);
		#1;
		reg_rd = 1'b0;
		chk(what, 17'(exp), 17'(reg_rdata));
	endtask

	// Checks the code port and the status read, whose top bits stay zero.
	task automatic st(input logic [5:0] exp);
		chk("state code", 17'(exp), 17'(controller_state_code));
		rd(CTRL_STAT_ADDR, "status", {2'b00, exp});
	endtask

	task automatic busy(input logic [2:0] top);
		for (int i = 0; i < 4 && controller_state_code[5:3] !== top; i++)
			@(posedge core_clk) #1;
		chk("busy code", 17'(top), 17'(controller_state_code[5:3]));
	endtask

	task automatic settle();
		repeat (12) @(posedge core_clk);
		#1;
	endtask

	task automatic unlock(input logic [7:0] p);
		wr(PAGE_SEL_ADDR, p);
		wr(CTRL_STAT_ADDR, KEY_FIRST);
		wr(CTRL_STAT_ADDR, KEY_SECOND);
		wr(PAGE_SEL_ADDR, p);
	endtask

	task automatic try_erase(input logic [7:0] p);
		int n0;
		n0 = n_ers;
		unlock(p);
		wr(CTRL_STAT_ADDR, CMD_PAGE_ERS);
		settle();
		chk_n("erase count", n0 + op_ok(p), n_ers);
		if (op_ok(p) == 1)
			chk("erase page", 17'(p), 17'(last_epage));
		chk("state code", 17'(ST_LOCKED), 17'(controller_state_code));
	endtask

	task automatic try_prog(input logic [7:0] p);
		int n0;
		logic [16:0] a;
		logic [7:0] d;
		n0 = n_prog;
		a = {p, 9'($urandom)};
		d = 8'($urandom);
		unlock(p);
		mw(a, d);
		settle();
		chk_n("program count", n0 + op_ok(p), n_prog);
		if (op_ok(p) == 1)
		begin
			chk("program address", a, last_paddr);
			chk("program data", 17'(d), 17'(last_pdata));
		end
		wr(CTRL_STAT_ADDR, 8'h00);
		st(ST_LOCKED);
	endtask

	task automatic do_reset();
		nrst = 1'b0;
		repeat (8) @(posedge core_clk);
		#1;
		nrst = 1'b1;
		prot_model = 8'h00;
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		void'($urandom(94694));
		{reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
		{mem_wr, mem_addr, mem_wdata, dbg_mass_erase} = '0;
		main_opt = 1'b1;
		high_opt = 1'b0;
		do_reset();
		st(ST_LOCKED);
		mw(17'($urandom), 8'h5a);
		wr(CTRL_STAT_ADDR, CMD_PAGE_ERS);
		settle();
		chk_n("locked requests", 0, n_prog + n_ers);
		pg = {3'($urandom_range(6, 1)), 5'($urandom)};
		wr(PAGE_SEL_ADDR, pg);
		wr(CTRL_STAT_ADDR, KEY_FIRST);
		st(ST_KEY1);
		wr(CTRL_STAT_ADDR, KEY_SECOND);
		st(ST_KEY2);
		wr(PAGE_SEL_ADDR, pg);
		st(ST_UNLOCKED);
		repeat (2)
		begin
			mw({pg, 9'($urandom)}, 8'($urandom));
			busy(3'b001);
			settle();
			st(ST_UNLOCKED);
		end
		chk_n("program count", 2, n_prog);
		wr(CTRL_STAT_ADDR, CMD_PAGE_ERS);
		settle();
		chk_n("erase after program", 0, n_ers);
		st(ST_LOCKED);
		unlock(pg);
		wr(CTRL_STAT_ADDR, CMD_PAGE_ERS);
		busy(3'b010);
		settle();
		chk("erase page", 17'(pg), 17'(last_epage));
		unlock(pg);
		wr(CTRL_STAT_ADDR, 8'($urandom_range(8'h94, 8'h00)));
		st(ST_LOCKED);
		wr(PAGE_SEL_ADDR, pg);
		wr(CTRL_STAT_ADDR, KEY_FIRST);
		wr(CTRL_STAT_ADDR, KEY_SECOND);
		wr(PAGE_SEL_ADDR, pg ^ 8'h01);
		st(ST_LOCKED);
		wr(PAGE_SEL_ADDR, pg);
		wr(CTRL_STAT_ADDR, KEY_SECOND);
		st(ST_LOCKED);
		wr(PAGE_SEL_ADDR, pg);
		wr(CTRL_STAT_ADDR, KEY_FIRST);
		wr(CTRL_STAT_ADDR, KEY_FIRST);
		st(ST_LOCKED);
		wr(CTRL_STAT_ADDR, CMD_SECT_SEL);
		st(ST_SECT_SEL);
		wr(PAGE_SEL_ADDR, 8'h01 << pg[7:5]);
		prot_model[pg[7:5]] = 1'b1;
		rd(PAGE_SEL_ADDR, "protect read", prot_model);
		wr(CTRL_STAT_ADDR, 8'h00);
		try_erase(pg);
		try_prog(pg);
		try_erase(pg ^ 8'h20);
		wr(CTRL_STAT_ADDR, CMD_SECT_SEL);
		wr(PAGE_SEL_ADDR, 8'h00);
		rd(PAGE_SEL_ADDR, "protect kept", prot_model);
		wr(CTRL_STAT_ADDR, 8'h00);
		try_erase(pg);
		do_reset();
		wr(CTRL_STAT_ADDR, CMD_SECT_SEL);
		rd(PAGE_SEL_ADDR, "protect after reset", 8'h00);
		wr(CTRL_STAT_ADDR, 8'h00);
		try_erase(pg);
		main_opt = 1'b0;
		settle();
		try_erase(pg);
		try_prog(pg);
		main_opt = 1'b1;
		high_opt = 1'b1;
		settle();
		try_prog(pg);
		chk_n("user mass erase", 0, n_mass);
		dbg_mass_erase = 1'b1;
		busy(3'b100);
		settle();
		dbg_mass_erase = 1'b0;
		chk_n("debug mass erase", 1, n_mass);
		close_out();
	end
endmodule
